// ### canopen_emergency_telegram_builder.sv
// The implementer's own choices: strobed register access and the register offsets.
`include "emcy_params.svh"
`timescale 1ns/1ps
`default_nettype none

module canopen_emergency_telegram_builder #(
	parameter int MAP_W = 64
) (
	// clock and reset
	input  wire logic                  ref_clk_i,
	input  wire logic                  rst_i,
	// register port
	input  wire logic [7:0]            addr_i,
	input  wire logic [31:0]           wdata_i,
	input  wire logic                  wr_i,
	input  wire logic                  rd_i,
	output logic [31:0]                rdata_o,
	// fault sources
	input  wire emcy_pkg::fault_in_t   fault_i,
	input  wire emcy_pkg::detail_t     detail_i,
	input  wire logic                  sync_seen_i,
	input  wire logic                  sync_fail_i,
	input  wire logic                  guard_seen_i,
	input  wire logic                  hb_seen_i,
	input  wire logic [MAP_W-1:0]      mod_map_i,
	input  wire logic                  cfg_saved_i,
	// telegram to can controller
	output emcy_pkg::frame_t           tx_frame_o,
	output logic                       tx_valid_o,
	input  wire logic                  tx_ready_i,
	output logic                       half_rate_o
);

	localparam int NS = 14;

	// registers
	logic [31:0] ctrl_q;
	logic [31:0] sync_per_q;
	logic [31:0] guard_q;
	logic [15:0] hb_q;
	logic [31:0] count_q;
	logic [31:0] rdata_q;

	// timers
	logic [7:0]  us_pre_q;
	logic [9:0]  ms_pre_q;
	logic [31:0] sync_cnt_q;
	logic [23:0] guard_cnt_q;
	logic [15:0] hb_cnt_q;
	logic        sync_to_q;
	logic        guard_to_q;
	logic        hb_to_q;

	// configuration snapshot
	logic [MAP_W-1:0] map_q;
	logic             map_ok_q;

	// fault tracking
	logic [NS-1:0] act;
	logic [NS-1:0] prev_q;
	logic [NS-1:0] pend_r_q;
	logic [NS-1:0] pend_c_q;
	logic [NS-1:0] take_r;
	logic [NS-1:0] take_c;

	emcy_pkg::frame_t frame_q;
	logic             valid_q;
	logic             half_q;

	// register decode
	wire sel_ctrl  = addr_i == `EMCY_REG_CTRL;
	wire sel_sync  = addr_i == `EMCY_REG_SYNC;
	wire sel_guard = addr_i == `EMCY_REG_GUARD;
	wire sel_hb    = addr_i == `EMCY_REG_HB;
	wire sel_stat  = addr_i == `EMCY_REG_STATUS;
	wire sel_cnt   = addr_i == `EMCY_REG_COUNT;

	wire        en      = ctrl_q[`EMCY_CTRL_EN];
	wire [6:0]  node    = ctrl_q[`EMCY_CTRL_NODE_LO +: 7];
	wire        cust    = ctrl_q[`EMCY_CTRL_CUST];
	wire [10:0] cust_id = ctrl_q[`EMCY_CTRL_ID_LO +: 11];

	// tick generation
	wire us_tick = us_pre_q == 8'(`EMCY_US_CYC - 1);
	wire ms_tick = us_tick && (ms_pre_q == 10'(`EMCY_MS_US - 1));

	// watchdog limits; zero disables each watchdog
	wire [23:0] guard_lim = 24'(guard_q[15:0] * guard_q[23:16]);
	wire sync_exp  = sync_per_q != 32'h0 && sync_cnt_q >= sync_per_q;
	wire guard_exp = guard_lim != 24'h0 && guard_cnt_q >= guard_lim;
	wire hb_exp    = hb_q != 16'h0 && hb_cnt_q >= hb_q;

	// altered composition only counts once a save was recorded
	wire hw_chg = map_ok_q && (mod_map_i != map_q);

	// source order: index fixes arbitration priority
	assign act = {
		fault_i.term,                   // 13
		fault_i.ebus,                   // 12
		fault_i.nvm,                    // 11
		fault_i.unsup,                  // 10
		hw_chg,                         // 9
		fault_i.tx_late,                // 8
		fault_i.evt_to,                 // 7
		guard_to_q | hb_to_q,           // 6
		sync_to_q | sync_fail_i,        // 5
		fault_i.pdo_len,                // 4
		fault_i.rxq_ovr,                // 3
		fault_i.txq_ovr,                // 2
		fault_i.bus_off,                // 1
		fault_i.warn                    // 0
	};

	localparam logic [NS-1:0][7:0] TRIG = {
		8'h10, 8'h0f, 8'h0e, 8'h0c, 8'h09, 8'h0b, 8'h0a,
		8'h08, 8'h07, 8'h06, 8'h04, 8'h03, 8'h02, 8'h01
	};
	localparam logic [NS-1:0] IS_DEV = 14'h3e00;

	// bit fields from live faults
	wire [7:0] comm = {act[0], act[1], act[2] | act[8], act[3],
		act[7], act[4], act[5], act[6]};
	wire [7:0] dev = {act[9], 2'h0, act[10], 1'h0, act[11],
		act[12], act[13]};
	wire       any_f = |act;
	wire [7:0] fault_register_byte = !any_f ? 8'h00 :
		(`EMCY_ER_ANY | (|comm ? `EMCY_ER_COMM : 8'h00));

	wire [NS-1:0] rise = act & ~prev_q;
	wire [NS-1:0] fall = ~act & prev_q;

	// arbitration: lowest source first, raise before clear
	logic       hit;
	logic       hit_clr;
	logic [3:0] hit_idx;
	always_comb begin
		hit = 1'b0;
		hit_clr = 1'b0;
		hit_idx = 4'h0;
		for (int k = NS - 1; k >= 0; k--) begin
			if (pend_r_q[k] || pend_c_q[k]) begin
				hit = 1'b1;
				hit_clr = !pend_r_q[k];
				hit_idx = 4'(k);
			end
		end
	end

	// no new telegram is loaded while bus off is active; one already held stays offered
	wire take = hit && en && !valid_q && !act[1];

	genvar g;
	generate
		for (g = 0; g < NS; g++) begin : g_take
			assign take_r[g] = take && !hit_clr && hit_idx == 4'(g);
			assign take_c[g] = take && hit_clr && hit_idx == 4'(g);
		end
	endgenerate

	// telegram assembly
	wire [7:0] trig_sel = (hit_clr && hit_idx == 4'd1) ?
		`EMCY_TRIG_BUSOFF : TRIG[hit_idx];
	wire [7:0] ec_hi = hit_clr ? 8'h00 :
		(IS_DEV[hit_idx] ? `EMCY_EC_DEV : `EMCY_EC_COMM);

	logic [7:0] info0;
	logic [7:0] info1;
	always_comb begin
		info0 = 8'h00;
		info1 = 8'h00;
		if (act[13]) begin
			info0 = detail_i.term_pos;
			info1 = detail_i.term_diag;
		end
		if (trig_sel == TRIG[4]) begin
			info0 = detail_i.pdo_exp;
			info1 = detail_i.pdo_cur;
		end else if (trig_sel == TRIG[10]) begin
			info1 = detail_i.unsup_pos;
		end else if (trig_sel == TRIG[12]) begin
			info0 = detail_i.ebus_type;
		end else if (trig_sel == TRIG[13]) begin
			info0 = detail_i.term_pos;
			info1 = detail_i.term_diag;
		end
	end

	emcy_pkg::frame_t nxt;
	// end of bus off keeps its own 40 trigger even when nothing else is active
	wire all_clr = hit_clr && !any_f && hit_idx != 4'd1;
	assign nxt.id    = cust ? cust_id : (`EMCY_ID_BASE + 11'(node));
	assign nxt.ec_lo = 8'h00;
	assign nxt.ec_hi = all_clr ? 8'h00 : ec_hi;
	assign nxt.fault_register_byte  = fault_register_byte;
	assign nxt.comm  = comm;
	assign nxt.dev   = dev;
	assign nxt.trig  = all_clr ? 8'h00 : trig_sel;
	assign nxt.info0 = all_clr ? 8'h00 : info0;
	assign nxt.info1 = all_clr ? 8'h00 : info1;

	// read mux
	wire [31:0] stat = {14'h0, half_q, valid_q, dev, comm};
	wire [31:0] rsel =
		sel_ctrl  ? ctrl_q :
		sel_sync  ? sync_per_q :
		sel_guard ? guard_q :
		sel_hb    ? {16'h0, hb_q} :
		sel_stat  ? stat :
		sel_cnt   ? count_q : 32'h0;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_q <= `EMCY_CTRL_RST;
			sync_per_q <= 32'h0;
			guard_q <= 32'h0;
			hb_q <= 16'h0;
		end else if (wr_i) begin
			if (sel_ctrl)
				ctrl_q <= wdata_i;
			else if (sel_sync)
				sync_per_q <= wdata_i;
			else if (sel_guard)
				guard_q <= {8'h0, wdata_i[23:0]};
			else if (sel_hb)
				hb_q <= wdata_i[15:0];
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i)
			rdata_q <= 32'h0;
		else
			rdata_q <= rd_i ? rsel : 32'h0;
	end

	// time base
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			us_pre_q <= 8'h0;
			ms_pre_q <= 10'h0;
		end else begin
			us_pre_q <= us_tick ? 8'h0 : us_pre_q + 8'h1;
			if (us_tick)
				ms_pre_q <= ms_tick ? 10'h0 : ms_pre_q + 10'h1;
		end
	end

	// sync watchdog in microseconds, fault holds until next sync
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync_cnt_q <= 32'h0;
			sync_to_q <= 1'b0;
		end else if (sync_seen_i) begin
			sync_cnt_q <= 32'h0;
			sync_to_q <= 1'b0;
		end else begin
			if (us_tick && !sync_exp)
				sync_cnt_q <= sync_cnt_q + 32'h1;
			if (sync_exp)
				sync_to_q <= 1'b1;
		end
	end

	// guarding and heartbeat watchdogs in milliseconds
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			guard_cnt_q <= 24'h0;
			guard_to_q <= 1'b0;
		end else if (guard_seen_i) begin
			guard_cnt_q <= 24'h0;
			guard_to_q <= 1'b0;
		end else begin
			if (ms_tick && !guard_exp)
				guard_cnt_q <= guard_cnt_q + 24'h1;
			if (guard_exp)
				guard_to_q <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			hb_cnt_q <= 16'h0;
			hb_to_q <= 1'b0;
		end else if (hb_seen_i) begin
			hb_cnt_q <= 16'h0;
			hb_to_q <= 1'b0;
		end else begin
			if (ms_tick && !hb_exp)
				hb_cnt_q <= hb_cnt_q + 16'h1;
			if (hb_exp)
				hb_to_q <= 1'b1;
		end
	end

	// composition recorded on each successful save
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			map_q <= '0;
			map_ok_q <= 1'b0;
		end else if (cfg_saved_i) begin
			map_q <= mod_map_i;
			map_ok_q <= 1'b1;
		end
	end

	// pending events; a new edge wins over the take of the same bit
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			prev_q <= '0;
			pend_r_q <= '0;
			pend_c_q <= '0;
		end else begin
			prev_q <= act;
			// the bus off raise itself cannot be sent and is dropped; other raises stay pending
			pend_r_q <= ((pend_r_q & ~take_r) | rise) & ~(NS'(1) << 1);
			pend_c_q <= (pend_c_q & ~take_c) | fall;
		end
	end

	// telegram holding register, stable until the controller takes it
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			frame_q <= '0;
			valid_q <= 1'b0;
			count_q <= 32'h0;
		end else if (valid_q) begin
			if (tx_ready_i) begin
				valid_q <= 1'b0;
				count_q <= count_q + 32'h1;
			end
		end else if (take) begin
			frame_q <= nxt;
			valid_q <= 1'b1;
		end
	end

	// txpdos go out every second sync while late
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i)
			half_q <= 1'b0;
		else
			half_q <= act[8];
	end

	assign rdata_o = rdata_q;
	assign tx_frame_o = frame_q;
	assign tx_valid_o = valid_q;
	assign half_rate_o = half_q;

	// checks
	property p_id;
		@(posedge ref_clk_i) disable iff (rst_i)
		take && !cust |=> tx_frame_o.id == `EMCY_ID_BASE + 11'(node);
	endproperty
	a_id: assert property (p_id) else $error("bad telegram id");

	property p_comm;
		@(posedge ref_clk_i) disable iff (rst_i)
		$rose(tx_valid_o) && tx_frame_o.ec_hi == `EMCY_EC_COMM |->
			tx_frame_o.fault_register_byte == 8'h91 && tx_frame_o.ec_lo == 8'h00;
	endproperty
	a_comm: assert property (p_comm) else $error("bad comm header");

	property p_dev;
		@(posedge ref_clk_i) disable iff (rst_i)
		$rose(tx_valid_o) && tx_frame_o.ec_hi == `EMCY_EC_DEV |->
			tx_frame_o.fault_register_byte[0] && tx_frame_o.fault_register_byte[7] && tx_frame_o.dev != 8'h00;
	endproperty
	a_dev: assert property (p_dev) else $error("bad device header");

	property p_zero;
		@(posedge ref_clk_i) disable iff (rst_i)
		take && all_clr |=> tx_frame_o[63:0] == 64'h0;
	endproperty
	a_zero: assert property (p_zero) else $error("all clear not zero");

	property p_term;
		@(posedge ref_clk_i) disable iff (rst_i)
		$rose(tx_valid_o) && tx_frame_o.trig == 8'h10 |-> tx_frame_o.dev[0];
	endproperty
	a_term: assert property (p_term) else $error("terminal bit missing");

	property p_busoff;
		@(posedge ref_clk_i) disable iff (rst_i)
		act[1] |=> !$rose(tx_valid_o);
	endproperty
	a_busoff: assert property (p_busoff) else $error("sent during bus off");

	property p_hold;
		@(posedge ref_clk_i) disable iff (rst_i)
		tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_frame_o);
	endproperty
	a_hold: assert property (p_hold) else $error("telegram changed");

	property p_sync;
		@(posedge ref_clk_i) disable iff (rst_i)
		sync_exp && !sync_seen_i |=> sync_to_q ##0 act[5];
	endproperty
	a_sync: assert property (p_sync) else $error("sync timeout missed");

	property p_clr;
		@(posedge ref_clk_i) disable iff (rst_i)
		fall[0] |=> pend_c_q[0];
	endproperty
	a_clr: assert property (p_clr) else $error("clear lost");

	c_send: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		tx_valid_o && tx_ready_i);
	c_allclr: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		take && hit_clr && act == '0);
	c_busoff: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		take && hit_clr && hit_idx == 4'd1);

endmodule

`default_nettype wire

// ### emcy_params.svh
`ifndef EMCY_PARAMS_SVH
`define EMCY_PARAMS_SVH

// register offsets (byte addresses)
`define EMCY_REG_CTRL     8'h00
`define EMCY_REG_SYNC     8'h04
`define EMCY_REG_GUARD    8'h08
`define EMCY_REG_HB       8'h0c
`define EMCY_REG_STATUS   8'h10
`define EMCY_REG_COUNT    8'h14

// control fields
`define EMCY_CTRL_EN      0
`define EMCY_CTRL_NODE_LO 8
`define EMCY_CTRL_CUST    15
`define EMCY_CTRL_ID_LO   16
`define EMCY_CTRL_RST     32'h0000_0101

// telegram constants
`define EMCY_ID_BASE      11'h080
`define EMCY_EC_COMM      8'h81
`define EMCY_EC_DEV       8'h50
`define EMCY_ER_ANY       8'h81
`define EMCY_ER_COMM      8'h10
`define EMCY_TRIG_BUSOFF  8'h40

// timing: tick of 1 us at a 5 ns clock, 1 ms = 1000 us
`define EMCY_CLK_PS       5000
`define EMCY_TICK_US      1
`define EMCY_US_CYC       ((`EMCY_TICK_US * 1000000) / `EMCY_CLK_PS)
`define EMCY_MS_US        1000

`endif

// ### emcy_pkg.sv
package emcy_pkg;

	// one fault source per field, levels from coupler logic
	typedef struct packed {
		logic term;
		logic ebus;
		logic nvm;
		logic unsup;
		logic tx_late;
		logic evt_to;
		logic pdo_len;
		logic rxq_ovr;
		logic txq_ovr;
		logic bus_off;
		logic warn;
	} fault_in_t;

	typedef struct packed {
		logic [7:0] pdo_exp;
		logic [7:0] pdo_cur;
		logic [7:0] unsup_pos;
		logic [7:0] ebus_type;
		logic [7:0] term_pos;
		logic [7:0] term_diag;
	} detail_t;

	// data bytes in send order, byte 0 first
	typedef struct packed {
		logic [10:0] id;
		logic [7:0]  ec_lo;
		logic [7:0]  ec_hi;
		logic [7:0]  fault_register_byte;
		logic [7:0]  comm;
		logic [7:0]  dev;
		logic [7:0]  trig;
		logic [7:0]  info0;
		logic [7:0]  info1;
	} frame_t;

endpackage

// ### canopen_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side taking telegrams; lat_i stretches the wait before each accept
module canopen_master_model (
	// clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	// telegram handshake
	input  wire logic       tx_valid_i,
	input  wire logic [3:0] lat_i,
	output logic            tx_ready_o
);
	logic [3:0] wait_q;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wait_q <= 4'h0;
			tx_ready_o <= 1'b0;
		end else if (tx_ready_o) begin
			// accept lasts one cycle so one telegram is never taken twice
			tx_ready_o <= 1'b0;
			wait_q <= 4'h0;
		end else if (tx_valid_i) begin
			if (wait_q >= lat_i)
				tx_ready_o <= 1'b1;
			else
				wait_q <= wait_q + 4'h1;
		end
	end
endmodule
`default_nettype wire

// ### canopen_emergency_telegram_builder_tb_top.sv
`include "emcy_params.svh"
`timescale 1ns/1ps
`default_nettype none
module canopen_emergency_telegram_builder_tb_top;
	logic                ref_clk_i;
	logic                rst_i;
	logic [7:0]          addr_i;
	logic [31:0]         wdata_i;
	logic                wr_i;
	logic                rd_i;
	logic [31:0]         rdata_o;
	emcy_pkg::fault_in_t fault_i;
	emcy_pkg::detail_t   detail_i;
	logic                sync_seen_i;
	logic                sync_fail_i;
	logic                guard_seen_i;
	logic                hb_seen_i;
	logic [63:0]         mod_map_i;
	logic                cfg_saved_i;
	emcy_pkg::frame_t    tx_frame_o;
	logic                tx_valid_o;
	logic                tx_ready_i;
	logic                half_rate_o;
	logic [3:0]          lat;
	int                  bad_count;
	int                  checks;
	int                  sent;
	int                  cyc;
	emcy_pkg::frame_t    f;

	canopen_emergency_telegram_builder #(.MAP_W(64)) canopen_emergency_telegram_builder_inst (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .fault_i(fault_i), .detail_i(detail_i),
		.sync_seen_i(sync_seen_i), .sync_fail_i(sync_fail_i), .guard_seen_i(guard_seen_i),
		.hb_seen_i(hb_seen_i),
		.mod_map_i(mod_map_i), .cfg_saved_i(cfg_saved_i), .tx_frame_o(tx_frame_o),
		.tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .half_rate_o(half_rate_o));

	canopen_master_model canopen_master_model_inst (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .tx_valid_i(tx_valid_o), .lat_i(lat),
		.tx_ready_o(tx_ready_i));

	always #2.5 ref_clk_i = ~ref_clk_i;

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// run needs well under 20000 cycles
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			end_of_test();
		end
	end

	task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1;
		chk(name, {32'h0, rdata_o}, {32'h0, exp});
	endtask

	task automatic set_f(input int idx, input logic v);
		@(posedge ref_clk_i);
		fault_i[idx] <= v;
	endtask

	// waits for an accepted telegram; the frame must not move while it waits
	task automatic get_frame(output emcy_pkg::frame_t fr);
		emcy_pkg::frame_t f0;
		logic             seen;
		seen = 1'b0;
		for (int n = 0; n < 3000; n++) begin
			@(negedge ref_clk_i);
			if (tx_valid_o === 1'b1) begin
				if (!seen)
					f0 = tx_frame_o;
				seen = 1'b1;
				if (tx_ready_i === 1'b1)
					break;
			end
		end
		fr = tx_frame_o;
		// a telegram that never got accepted counts as a mismatch
		chk("frame_taken", {63'h0, tx_ready_i === 1'b1}, 64'h1);
		chk("frame_hold", {63'h0, fr !== f0}, 64'h0);
		@(posedge ref_clk_i);
		sent++;
	endtask

	task automatic quiet(input string name);
		logic hit;
		hit = 1'b0;
		repeat (20) begin
			@(negedge ref_clk_i);
			if (tx_valid_o !== 1'b0)
				hit = 1'b1;
		end
		chk(name, {63'h0, hit}, 64'h0);
	endtask

	task automatic fault_case(input int idx, input logic [63:0] exp);
		emcy_pkg::frame_t fr;
		set_f(idx, 1'b1);
		get_frame(fr);
		chk("raise", fr[63:0], exp);
		chk("raise_id", 64'(fr.id), 64'h085);
		if (idx == 6)
			chk("half_rate_on", {63'h0, half_rate_o}, 64'h1);
		set_f(idx, 1'b0);
		get_frame(fr);
		chk("clear", fr[63:0], 64'h0);
		if (idx == 6)
			chk("half_rate_off", {63'h0, half_rate_o}, 64'h0);
	endtask

	initial begin
		ref_clk_i = 1'b0;
		rst_i = 1'b1;
		addr_i = 8'h00;
		wdata_i = 32'h0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		fault_i = '0;
		detail_i = 48'h0806_0503_0a82;
		sync_seen_i = 1'b0;
		sync_fail_i = 1'b0;
		guard_seen_i = 1'b0;
		hb_seen_i = 1'b0;
		mod_map_i = 64'h0000_0000_0000_00ff;
		cfg_saved_i = 1'b0;
		lat = 4'h5;
		bad_count = 0;
		checks = 0;
		sent = 0;
		cyc = 0;
		repeat (16) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		@(posedge ref_clk_i);
		rd(`EMCY_REG_CTRL, 32'h0000_0101, "ctrl_reset");
		// warning, then terminal fault, then both clear, against a slow far side
		set_f(0, 1'b1);
		get_frame(f);
		chk("warn_raise", f[63:0], 64'h0081_9180_0001_0000);
		chk("warn_id", 64'(f.id), 64'h081);
		set_f(10, 1'b1);
		get_frame(f);
		chk("term_raise", f[63:0], 64'h0050_9180_0110_0a82);
		rd(`EMCY_REG_STATUS, 32'h0000_0180, "status");
		wr(`EMCY_REG_STATUS, 32'hffff_ffff);
		rd(`EMCY_REG_STATUS, 32'h0000_0180, "status_ro");
		set_f(0, 1'b0);
		get_frame(f);
		chk("warn_clear", f[63:0], 64'h0000_8100_0101_0a82);
		set_f(10, 1'b0);
		get_frame(f);
		chk("all_clear", f[63:0], 64'h0);
		lat = 4'h0;
		wr(`EMCY_REG_CTRL, 32'h0000_0501);
		fault_case(2, 64'h0081_9120_0003_0000);
		fault_case(3, 64'h0081_9110_0004_0000);
		fault_case(4, 64'h0081_9104_0006_0806);
		fault_case(5, 64'h0081_9108_000a_0000);
		fault_case(6, 64'h0081_9120_000b_0000);
		fault_case(7, 64'h0050_8100_100c_0005);
		fault_case(8, 64'h0050_8100_040e_0000);
		fault_case(9, 64'h0050_8100_020f_0300);
		// disabled block holds the event until enabled again
		wr(`EMCY_REG_CTRL, 32'h0000_0500);
		set_f(8, 1'b1);
		quiet("disabled_quiet");
		wr(`EMCY_REG_CTRL, 32'h0000_0501);
		get_frame(f);
		chk("enable_late", f[63:0], 64'h0050_8100_040e_0000);
		set_f(8, 1'b0);
		get_frame(f);
		chk("enable_clear", f[63:0], 64'h0);
		// nothing leaves while bus off; its end is announced
		set_f(1, 1'b1);
		quiet("busoff_quiet");
		set_f(1, 1'b0);
		get_frame(f);
		chk("busoff_code", {48'h0, f.ec_lo, f.ec_hi}, 64'h0);
		chk("busoff_trig", 64'(f.trig), 64'h040);
		// sync failure level, then sync timeout at 3 us
		@(posedge ref_clk_i);
		sync_fail_i <= 1'b1;
		get_frame(f);
		chk("sync_fail", f[63:0], 64'h0081_9102_0007_0000);
		@(posedge ref_clk_i);
		sync_fail_i <= 1'b0;
		get_frame(f);
		chk("sync_fail_clear", f[63:0], 64'h0);
		wr(`EMCY_REG_SYNC, 32'h0000_0003);
		get_frame(f);
		chk("sync_timeout", f[63:0], 64'h0081_9102_0007_0000);
		wr(`EMCY_REG_SYNC, 32'h0);
		@(posedge ref_clk_i);
		sync_seen_i <= 1'b1;
		@(posedge ref_clk_i);
		sync_seen_i <= 1'b0;
		get_frame(f);
		chk("sync_seen_clear", f[63:0], 64'h0);
		// composition changed after a save, then restored
		@(posedge ref_clk_i);
		cfg_saved_i <= 1'b1;
		@(posedge ref_clk_i);
		cfg_saved_i <= 1'b0;
		mod_map_i <= 64'h0000_0000_0000_01ff;
		get_frame(f);
		chk("hw_changed", f[63:0], 64'h0050_8100_8009_0000);
		@(posedge ref_clk_i);
		mod_map_i <= 64'h0000_0000_0000_00ff;
		get_frame(f);
		chk("hw_restored", f[63:0], 64'h0);
		rd(`EMCY_REG_CTRL, 32'h0000_0501, "ctrl_rw");
		rd(8'h40, 32'h0, "unmapped");
		rd(`EMCY_REG_COUNT, 32'(sent), "sent_count");
		end_of_test();
	end
endmodule
`default_nettype wire
